// ---- common/lpst_pkg.sv ----
// Purpose: shared constants and types for the panel sync timing block
// Assumes: one pixel per pclk cycle, apb with 32-bit data
// Notes:   register indices are kept, byte address is index times four
package lpst_pkg;

    localparam int unsigned ADDR_W   = 19;
    localparam int unsigned CNT_W    = 11;

    // register indices, byte address = index * 4
    localparam logic [16:0] IDX_MODE    = 17'h1ffe1;
    localparam logic [16:0] IDX_HSIZE   = 17'h1ffe4;
    localparam logic [16:0] IDX_VSIZE_L = 17'h1ffe5;
    localparam logic [16:0] IDX_VSIZE_H = 17'h1ffe6;
    localparam logic [16:0] IDX_LPS     = 17'h1ffe7;
    localparam logic [16:0] IDX_HBLANK  = 17'h1ffe8;
    localparam logic [16:0] IDX_FPS     = 17'h1ffe9;
    localparam logic [16:0] IDX_VBLANK  = 17'h1ffea;
    localparam logic [16:0] IDX_ACB     = 17'h1ffeb;
    localparam logic [16:0] IDX_SCR1_L  = 17'h1ffec;
    localparam logic [16:0] IDX_IRQ_STS = 17'h1ffee;
    localparam logic [16:0] IDX_IRQ_EN  = 17'h1ffef;
    localparam logic [16:0] IDX_IRQ_CLR = 17'h1fff0;

    // field positions
    localparam int unsigned MODE_AM_BIT   = 7;
    localparam int unsigned VBL_STS_BIT   = 7;
    localparam int unsigned IRQ_LINE_BIT  = 0;
    localparam int unsigned IRQ_FRAME_BIT = 1;
    localparam int unsigned IRQ_VBL_BIT   = 2;
    localparam int unsigned IRQ_W         = 3;

    // timing counts, in pixels or groups of eight pixels
    localparam logic [2:0]  GROUP_SHIFT  = 3'h3;
    localparam logic [5:0]  HBLANK_ADD   = 6'h04;
    localparam logic [5:0]  LPS_ADD      = 6'h02;
    localparam logic [3:0]  LINE_PULSE_W = 4'h8;

    typedef struct packed {
        logic       active_matrix_mode;
        logic [6:0] hsize;
        logic [9:0] vsize;
        logic [4:0] lps;
        logic [4:0] hblank;
        logic [5:0] fps;
        logic [5:0] vblank;
        logic [5:0] acb_rate;
        logic [7:0] scr1_low;
    } lpst_cfg_t;

    localparam lpst_cfg_t CFG_RST = '{
        active_matrix_mode: 1'b0,
        hsize:    7'h03,
        vsize:    10'h000,
        lps:      5'h00,
        hblank:   5'h00,
        fps:      6'h01,
        vblank:   6'h01,
        acb_rate: 6'h00,
        scr1_low: 8'h00
    };
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

endpackage : lpst_pkg

// ---- verilog/lpst_top.sv ----
// Purpose: line/frame sync, non-display periods and ac-bias for an lcd panel
// Assumes: pclk is the pixel clock, one pixel per cycle
// Notes:   apb slave, registers at index*4, unmapped access gets pslverr
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
module lpst_top (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [lpst_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic                           line_sync_pulse,
    output logic                           frame_sync_pulse,
    output logic                           ac_bias_output,
    output logic                           display_active,
    output logic                           irq
);

    localparam int unsigned CW = lpst_pkg::CNT_W;

    lpst_pkg::lpst_cfg_t   cfg_q;
    logic [CW-1:0]         h_cnt_q;
    logic [CW-1:0]         v_cnt_q;
    logic [CW-1:0]         h_nxt;
    logic [CW-1:0]         v_nxt;
    logic [CW-1:0]         h_act;
    logic [CW-1:0]         h_tot;
    logic [CW-1:0]         v_act;
    logic [CW-1:0]         v_tot;
    logic [CW-1:0]         lp_set_pos;
    logic [CW-1:0]         fp_line;
    logic                  am;
    logic                  lp_set;
    logic                  fp_set;
    logic                  vb_nxt;
    logic                  vb_set;
    logic                  vblank_q;
    logic                  line_q;
    logic [3:0]            lw_cnt_q;
    logic                  frame_q;
    logic                  ac_q;
    logic [5:0]            ac_cnt_q;
    logic                  de_q;
    logic [lpst_pkg::IRQ_W-1:0] sts_q;
    logic [lpst_pkg::IRQ_W-1:0] en_q;
    logic [lpst_pkg::IRQ_W-1:0] evt;
    logic [lpst_pkg::IRQ_W-1:0] clr;
    logic                  irq_q;
    logic [31:0]           rdata_q;
    logic                  ready_q;
    logic                  err_q;
    logic                  acc;
    logic                  wr;
    logic [16:0]           idx;
    logic                  hit;
    logic [7:0]            rmux;

    assign am = cfg_q.active_matrix_mode;

    // geometry from the programmed sizes
    assign h_act = CW'({4'h0, cfg_q.hsize} + 11'h001) << lpst_pkg::GROUP_SHIFT;
    assign h_tot = h_act + (CW'({5'h00, cfg_q.hblank} + lpst_pkg::HBLANK_ADD)
                            << lpst_pkg::GROUP_SHIFT);
    assign v_act = CW'({1'b0, cfg_q.vsize} + 11'h001);
    assign v_tot = v_act + CW'(cfg_q.vblank);

    // line pulse set one cycle ahead so the flop rises on the target pixel
    // passive panels ignore the start field and pulse at blank start
    assign lp_set_pos = am
        ? h_act + (CW'({1'b0, cfg_q.lps} + lpst_pkg::LPS_ADD)
                   << lpst_pkg::GROUP_SHIFT) - 11'h002
        : h_act - 11'h001;
    assign lp_set = (h_cnt_q == lp_set_pos);

    // frame pulse covers line last_line+N, passive uses line zero
    assign fp_line = am ? v_act - 11'h001 + CW'(cfg_q.fps) : 11'h000;

    // counters: active part then blank part, forever
    always_comb begin
        h_nxt = h_cnt_q + 11'h001;
        v_nxt = v_cnt_q;
        if (h_cnt_q >= h_tot - 11'h001) begin
            h_nxt = 11'h000;
            v_nxt = (v_cnt_q >= v_tot - 11'h001) ? 11'h000
                                                  : v_cnt_q + 11'h001;
        end
    end

    assign fp_set = (h_nxt == 11'h000) && (v_nxt == fp_line);
    assign vb_nxt = (v_nxt >= v_act);
    assign vb_set = vb_nxt && !vblank_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h_cnt_q <= 11'h000;
            v_cnt_q <= 11'h000;
        end else begin
            h_cnt_q <= h_nxt;
            v_cnt_q <= v_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            de_q     <= 1'b0;
            vblank_q <= 1'b0;
        end else begin
            de_q     <= (h_nxt < h_act) && !vb_nxt;
            vblank_q <= vb_nxt;
        end
    end

    // line pulse eight pixels wide; fits since the start never passes blank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_q   <= 1'b0;
            lw_cnt_q <= 4'h0;
        end else if (lp_set) begin
            line_q   <= 1'b1;
            lw_cnt_q <= lpst_pkg::LINE_PULSE_W - 4'h1;
        end else if (lw_cnt_q != 4'h0) begin
            lw_cnt_q <= lw_cnt_q - 4'h1;
        end else begin
            line_q   <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_q <= 1'b0;
        end else if (fp_set) begin
            frame_q <= 1'b1;
        end else if (h_nxt == 11'h000) begin
            frame_q <= 1'b0;
        end
    end

    // ac-bias only runs for passive panels, held low otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ac_q     <= 1'b0;
            ac_cnt_q <= 6'h00;
        end else if (am) begin
            ac_q     <= 1'b0;
            ac_cnt_q <= 6'h00;
        end else if (cfg_q.acb_rate == 6'h00) begin
            ac_cnt_q <= 6'h00;
            if (fp_set) begin
                ac_q <= !ac_q;
            end
        end else if (lp_set) begin
            if (ac_cnt_q >= cfg_q.acb_rate) begin
                ac_q     <= !ac_q;
                ac_cnt_q <= 6'h00;
            end else begin
                ac_cnt_q <= ac_cnt_q + 6'h01;
            end
        end
    end

    // apb: answer on the second access cycle, so reads see a settled mux
    assign acc = psel && penable && ready_q;
    assign wr  = acc && pwrite;
    assign idx = paddr[lpst_pkg::ADDR_W-1:2];

    always_comb begin
        hit  = 1'b1;
        rmux = 8'h00;
        case (idx)
            lpst_pkg::IDX_MODE:    rmux = {am, 7'h00};
            lpst_pkg::IDX_HSIZE:   rmux = {1'b0, cfg_q.hsize};
            lpst_pkg::IDX_VSIZE_L: rmux = cfg_q.vsize[7:0];
            lpst_pkg::IDX_VSIZE_H: rmux = {6'h00, cfg_q.vsize[9:8]};
            lpst_pkg::IDX_LPS:     rmux = {3'h0, cfg_q.lps};
            lpst_pkg::IDX_HBLANK:  rmux = {3'h0, cfg_q.hblank};
            lpst_pkg::IDX_FPS:     rmux = {2'h0, cfg_q.fps};
            lpst_pkg::IDX_VBLANK:
                rmux = {vblank_q, 1'b0, cfg_q.vblank};
            lpst_pkg::IDX_ACB:     rmux = {2'h0, cfg_q.acb_rate};
            lpst_pkg::IDX_SCR1_L:  rmux = cfg_q.scr1_low;
            lpst_pkg::IDX_IRQ_STS: rmux = {5'h00, sts_q};
            lpst_pkg::IDX_IRQ_EN:  rmux = {5'h00, en_q};
            lpst_pkg::IDX_IRQ_CLR: rmux = 8'h00;
            default:               hit  = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else begin
            ready_q <= psel && penable && !ready_q;
            err_q   <= psel && penable && !ready_q && !hit;
            if (psel && penable && !ready_q && !pwrite) begin
                rdata_q <= {24'h00_0000, rmux};
            end
        end
    end

    // live settings; changing vblank mid-frame only disturbs that frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= lpst_pkg::CFG_RST;
            en_q  <= lpst_pkg::IRQ_RST;
        end else if (wr) begin
            case (idx)
                lpst_pkg::IDX_MODE:
                    cfg_q.active_matrix_mode <= pwdata[lpst_pkg::MODE_AM_BIT];
                lpst_pkg::IDX_HSIZE:   cfg_q.hsize       <= pwdata[6:0];
                lpst_pkg::IDX_VSIZE_L: cfg_q.vsize[7:0]  <= pwdata[7:0];
                lpst_pkg::IDX_VSIZE_H: cfg_q.vsize[9:8]  <= pwdata[1:0];
                lpst_pkg::IDX_LPS:     cfg_q.lps         <= pwdata[4:0];
                lpst_pkg::IDX_HBLANK:  cfg_q.hblank      <= pwdata[4:0];
                lpst_pkg::IDX_FPS:     cfg_q.fps         <= pwdata[5:0];
                lpst_pkg::IDX_VBLANK:  cfg_q.vblank      <= pwdata[5:0];
                lpst_pkg::IDX_ACB:     cfg_q.acb_rate    <= pwdata[5:0];
                lpst_pkg::IDX_SCR1_L:  cfg_q.scr1_low    <= pwdata[7:0];
                lpst_pkg::IDX_IRQ_EN:  en_q <= pwdata[lpst_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    always_comb begin
        evt = '0;
        evt[lpst_pkg::IRQ_LINE_BIT]  = lp_set;
        evt[lpst_pkg::IRQ_FRAME_BIT] = fp_set;
        evt[lpst_pkg::IRQ_VBL_BIT]   = vb_set;
        clr = (wr && idx == lpst_pkg::IDX_IRQ_CLR)
            ? pwdata[lpst_pkg::IRQ_W-1:0] : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_q <= lpst_pkg::IRQ_RST;
            irq_q <= 1'b0;
        end else begin
            sts_q <= (sts_q & ~clr) | evt;
            irq_q <= |(sts_q & en_q);
        end
    end

    assign prdata           = rdata_q;
    assign pready           = ready_q;
    assign pslverr          = err_q;
    assign line_sync_pulse  = line_q;
    assign frame_sync_pulse = frame_q;
    assign ac_bias_output   = ac_q;
    assign display_active   = de_q;
    assign irq              = irq_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // steps of a line pulse and of one register access
    sequence line_pulse_s;
        line_q [*8] ##1 !line_q;
    endsequence

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence apb_access_s;
        psel && penable && !ready_q;
    endsequence

    // a setting written on the judged edge moves the target, so skip it
    h_wrap_a: assert property (
        h_cnt_q == h_tot - 11'h001 |=> h_cnt_q == 11'h000)
        else $error("pixel counter did not wrap at line end");
    v_wrap_a: assert property (
        (h_cnt_q == h_tot - 11'h001) && (v_cnt_q == v_tot - 11'h001)
        |=> v_cnt_q == 11'h000)
        else $error("line counter did not wrap at frame end");
    line_pos_a: assert property (
        am && $rose(line_q) && $stable(cfg_q) |->
        h_cnt_q == h_act - 11'h001 + ((CW'(cfg_q.lps) + 11'h002) << 3))
        else $error("line pulse at wrong pixel in active mode");
    line_passive_a: assert property (
        !am && $rose(line_q) && $stable(cfg_q) |-> h_cnt_q == h_act)
        else $error("passive line pulse not at blank start");
    line_width_a: assert property (
        $rose(line_q) |-> line_pulse_s)
        else $error("line pulse width wrong");
    frame_pos_a: assert property (
        am && $rose(frame_q) && $stable(cfg_q) |->
        v_cnt_q == v_act - 11'h001 + CW'(cfg_q.fps) && h_cnt_q == 11'h000)
        else $error("frame pulse on wrong line");
    de_region_a: assert property (
        de_q && $stable(cfg_q) |-> h_cnt_q < h_act && v_cnt_q < v_act)
        else $error("display active outside the active region");
    vbl_status_a: assert property (
        psel && penable && !ready_q && !pwrite
        && idx == lpst_pkg::IDX_VBLANK |=> prdata[7] == $past(vblank_q)
        && vblank_q == (v_cnt_q >= v_act))
        else $error("vertical blank status bit wrong");
    ac_frame_a: assert property (
        !am && cfg_q.acb_rate == 6'h00 && fp_set |=> ac_q != $past(ac_q))
        else $error("ac-bias did not toggle on frame pulse");
    ac_line_a: assert property (
        !am && $changed(ac_q) && cfg_q.acb_rate != 6'h00 && $stable(cfg_q)
        |-> $rose(line_q))
        else $error("ac-bias toggled away from a line pulse");
    ac_active_a: assert property (
        am |=> !ac_q)
        else $error("ac-bias moved in active-matrix mode");
    apb_answer_a: assert property (
        apb_setup_s ##1 apb_access_s |=> ready_q)
        else $error("register access not answered in time");
    apb_pulse_a: assert property (ready_q |=> !ready_q)
        else $error("ready held longer than one cycle");
    apb_err_a: assert property (err_q |-> ready_q)
        else $error("error flagged without ready");
    // the set side must win when an event meets a clear
    sts_set_a: assert property (
        $rose(frame_q) |-> sts_q[lpst_pkg::IRQ_FRAME_BIT])
        else $error("frame event lost to a clear");
    irq_level_a: assert property (
        sts_q[lpst_pkg::IRQ_FRAME_BIT] && en_q[lpst_pkg::IRQ_FRAME_BIT]
        |=> irq_q)
        else $error("interrupt not raised for an enabled event");

endmodule : lpst_top

// ---- tb/lpst_panel_model.sv ----
// Purpose: panel-side observer that measures sync timing at the pins
// Assumes: one pixel per pclk, all panel pins active high
// Notes:   the panel only listens, so it drives nothing back into the block
`timescale 1ns/10ps
module lpst_panel_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic line_sync_pulse,
    input  wire logic frame_sync_pulse,
    input  wire logic ac_bias_output,
    input  wire logic display_active,
    output int        act_w,
    output int        lsp_off,
    output int        line_len,
    output int        fp_off,
    output int        vb_gap,
    output int        act_lines,
    output int        acb_lines,
    output int        frames,
    output int        toggles
);
    logic da_q, ls_q, fs_q, ac_q, ls_rise;
    int   run, low_n, since_ls, nlines, ls_n;

    assign ls_rise = presetn && line_sync_pulse && !ls_q;

    // counts are in pixels, taken from the last active pixel onward
    always @(posedge pclk) begin
        da_q     <= display_active;
        ls_q     <= line_sync_pulse;
        fs_q     <= frame_sync_pulse;
        ac_q     <= ac_bias_output;
        run      <= display_active ? run + 1 : 0;
        low_n    <= display_active ? 0 : low_n + 1;
        since_ls <= ls_rise ? 0 : since_ls + 1;
        if (da_q && !display_active)
            act_w <= run;
        // only a pulse that follows active pixels of its own line counts
        if (ls_rise && low_n < since_ls)
            lsp_off <= low_n + 1;
        if (ls_rise)
            line_len <= since_ls + 1;
        if (frame_sync_pulse && !fs_q)
            fp_off <= low_n + 1;
        // a gap longer than a line can only be the vertical blank
        if (display_active && !da_q) begin
            if (line_len > 0 && low_n >= line_len) begin
                vb_gap    <= low_n;
                act_lines <= nlines;
                nlines    <= 1;
                frames    <= frames + 1;
            end else begin
                nlines <= nlines + 1;
            end
        end
        if (ac_bias_output != ac_q) begin
            acb_lines <= ls_n + (ls_rise ? 1 : 0);
            ls_n      <= 0;
            toggles   <= toggles + 1;
        end else if (ls_rise) begin
            ls_n <= ls_n + 1;
        end
    end
endmodule : lpst_panel_model

// ---- tb/tb.sv ----
// Purpose: self-checking bench for the panel sync timing block
// Assumes: bench is the apb master, lpst_panel_model watches the pins
// Notes:   random settings keep the software limits on start values
`timescale 1ns/10ps
module tb;
    localparam int LIMIT = 100000;
    logic                        pclk    = 1'b0;
    logic                        presetn = 1'b0;
    logic                        psel    = 1'b0;
    logic                        penable = 1'b0;
    logic                        pwrite  = 1'b0;
    logic [lpst_pkg::ADDR_W-1:0] paddr   = '0;
    logic [31:0]                 pwdata  = '0;
    logic [31:0]                 prdata, d, seed;
    logic                        pready, pslverr, e, irq;
    logic                        line_sync_pulse, frame_sync_pulse;
    logic                        ac_bias_output, display_active;
    int act_w, lsp_off, line_len, fp_off, vb_gap, act_lines, acb_lines;
    int frames, toggles, error_cnt, compares, cyc;
    int hs, vs, hb, lps, fps, vb, ll, ha, r;

    always #2.5 pclk = ~pclk;

    lpst_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .line_sync_pulse,
        .frame_sync_pulse, .ac_bias_output, .display_active, .irq);

    lpst_panel_model panel_u (.pclk, .presetn, .line_sync_pulse,
        .frame_sync_pulse, .ac_bias_output, .display_active, .act_w,
        .lsp_off, .line_len, .fp_off, .vb_gap, .act_lines, .acb_lines,
        .frames, .toggles);

    function automatic int rnd(input int m);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return int'(seed % m);
    endfunction : rnd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // pready is judged at the rising edge; an idle cycle between transfers
    task automatic apb(input logic wr, input logic [16:0] idx, input int v);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [16:0] idx, input int v);
        apb(1'b1, idx, v);
    endtask : wr

    task automatic rd(input logic [16:0] idx);
        apb(1'b0, idx, 0);
    endtask : rd

    task automatic wait_cnt(input bit tog, input int n);
        int c0;
        c0 = tog ? toggles : frames;
        do @(negedge pclk); while ((tog ? toggles : frames) < c0 + n);
    endtask : wait_cnt

    task automatic close_out();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt = error_cnt + 1;
            close_out();
        end
    end

    initial begin
        seed = 32'h40dc0218;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(lpst_pkg::IDX_HSIZE);
        chk(d, 32'h3);
        rd(lpst_pkg::IDX_VBLANK);
        chk(d, 32'h1);
        rd(17'h00000);
        chk({d[30:0], e}, 32'h1);
        vb = 2 + rnd(6);
        wr(lpst_pkg::IDX_VBLANK, vb);
        wr(lpst_pkg::IDX_VSIZE_H, 0);
        // four active-matrix settings, then one passive, i==1 at the limits
        for (int i = 0; i < 5; i++) begin
            hs  = (i == 0) ? 3 : 3 + rnd(3);
            vs  = rnd(3);
            hb  = rnd(12);
            lps = (i == 1) ? hb : rnd(hb + 1);
            fps = (i == 1) ? vb : 1 + rnd(vb);
            wr(lpst_pkg::IDX_MODE, (i < 4) ? 32'h80 : 32'h0);
            wr(lpst_pkg::IDX_HSIZE, hs);
            wr(lpst_pkg::IDX_VSIZE_L, vs);
            wr(lpst_pkg::IDX_LPS, lps);
            wr(lpst_pkg::IDX_HBLANK, hb);
            wr(lpst_pkg::IDX_FPS, fps);
            ha = (hs + 1) * 8;
            ll = ha + (hb + 4) * 8;
            wait_cnt(1'b0, 3);
            chk(act_w, ha);
            chk(line_len, ll);
            chk(vb_gap, ll - ha + vb * ll);
            chk(act_lines, vs + 1);
            if (i < 4) begin
                chk(lsp_off, (lps + 2) * 8);
                chk(fp_off, fps * ll - ha + 1);
                @(posedge display_active);
                rd(lpst_pkg::IDX_VBLANK);
                chk(d, vb);
                @(posedge frame_sync_pulse);
                rd(lpst_pkg::IDX_VBLANK);
                chk(d, 32'h80 | vb);
            end else begin
                chk(lsp_off, 1);
                chk(fp_off, (vb + 1) * ll - ha + 1);
            end
        end
        for (int k = 0; k < 3; k++) begin
            r = (k < 2) ? k : 2 + rnd(6);
            wr(lpst_pkg::IDX_ACB, r);
            wait_cnt(1'b1, 3);
            chk(acb_lines, (r == 0) ? vs + 1 + vb : r + 1);
        end
        r = rnd(256);
        wr(lpst_pkg::IDX_SCR1_L, r);
        rd(lpst_pkg::IDX_SCR1_L);
        chk(d, r);
        rd(lpst_pkg::IDX_LPS);
        chk(d, lps);
        rd(lpst_pkg::IDX_HBLANK);
        chk(d, hb);
        rd(lpst_pkg::IDX_FPS);
        chk(d, fps);
        rd(lpst_pkg::IDX_IRQ_CLR);
        chk({d[30:0], e}, 32'h0);
        wr(lpst_pkg::IDX_MODE, 32'h80);
        wait_cnt(1'b0, 1);
        chk(ac_bias_output, 1'b0);
        wr(lpst_pkg::IDX_IRQ_EN, 32'h2);
        @(posedge frame_sync_pulse);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b1);
        rd(lpst_pkg::IDX_IRQ_STS);
        chk(d, 32'h7);
        wr(lpst_pkg::IDX_IRQ_EN, 32'h0);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b0);
        wr(lpst_pkg::IDX_IRQ_EN, 32'h2);
        wr(lpst_pkg::IDX_IRQ_CLR, 32'h7);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b0);
        rd(lpst_pkg::IDX_IRQ_STS);
        chk(d & 32'h2, 32'h0);
        close_out();
    end
endmodule : tb
